// File: rtl/i2cr_top.sv
// Two-wire serial slave with byte register space, AXI4-Lite access and reset sweep
//
// Overview of operation
// R1 - At power-up all registers load defaults before any serial access is served.
// R2 - Writing soft_reset_bit in the reset register reloads all defaults, anytime.
// R3 - Host writes zero to registers 0x03, 0x05 and 0x07 for low power.
// R4 - Host clears/sets listed bits at 0x06, 0x0A and 0x0B for low power.
// R5 - Complete two-wire slave controller, operating at fast-mode bus rates.
// R6 - Write: slave address with write bit acked, register address acked.
// R7 - Each write byte stored at current address, acked, then address increments.
// R8 - Master ends a single-byte write with stop right after first ack.
// R9 - Addressed read: set address, repeated start, read bytes from K upward.
// R10 - Master acks wanted bytes, nacks last; device releases data on nack.
// R11 - Read without register address starts at the current register location.
// R12 - Direction bit one means read, zero write; high ack slot means nack.
// R13 - Register pointer persists between transfers for address-less reads.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module i2cr_top
    import i2cr_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    // ------------------------------------------------------------------
    // Link domain: reset and pin conditioning
    // ------------------------------------------------------------------
    logic [2:0] lrst_q;
    logic link_rst_n;
    logic link_hold;
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic scl_f, scl_p, sda_f, sda_p;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[1:0], !link_hold};
    end
    assign link_rst_n = lrst_q[2];

    // Three stages; a level is accepted only once the last two agree
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            scl_f <= 1'b1;
            sda_f <= 1'b1;
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
            if (scl_q[1] == scl_q[2]) begin
                scl_f <= scl_q[2];
            end
            if (sda_q[1] == sda_q[2]) begin
                sda_f <= sda_q[2];
            end
            scl_p <= scl_f;
            sda_p <= sda_f;
        end
    end

    assign scl_rise = scl_f && !scl_p;
    assign scl_fall = !scl_f && scl_p;
    assign start_det = scl_f && scl_p && sda_p && !sda_f;
    assign stop_det = scl_f && scl_p && !sda_p && sda_f;

    // ------------------------------------------------------------------
    // Link domain: serial slave state machine
    // ------------------------------------------------------------------
    i2cr_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg, tx, ptr, rd_data;
    logic dir_rd, mnack;
    logic req_tgl, req_we;
    logic [7:0] req_addr, req_wdata;
    logic rsp_s1, rsp_s2, rsp_seen;
    logic rsp_tgl;
    logic [7:0] xfer_rdata;
    logic receiving;

    assign receiving = (state == ST_DEVADDR) || (state == ST_REGADDR) || (state == ST_WRDATA);

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            state <= ST_IDLE;
            cnt <= CNT_ZERO;
            shreg <= REG_DEFAULT;
            tx <= REG_DEFAULT;
            ptr <= REG_DEFAULT;
            dir_rd <= 1'b0;
            mnack <= 1'b0;
            req_tgl <= 1'b0;
            req_we <= 1'b0;
            req_addr <= REG_DEFAULT;
            req_wdata <= REG_DEFAULT;
        end else if (start_det) begin
            state <= ST_DEVADDR; // R9
            cnt <= CNT_ZERO;
        end else if (stop_det) begin
            state <= ST_IDLE; // R8
        end else begin
            if (receiving && scl_rise) begin
                shreg <= {shreg[6:0], sda_f};
                cnt <= cnt + CNT_STEP;
            end
            unique case (state)
                ST_IDLE: begin
                end
                ST_DEVADDR: begin
                    if (scl_fall && cnt == BITS_PER_BYTE) begin
                        cnt <= CNT_ZERO;
                        if (shreg[7:1] == DEV_ADDR) begin
                            state <= ST_DEVACK; // R6
                            dir_rd <= shreg[0]; // R12
                            if (shreg[0]) begin
                                // Fetch at the kept pointer during the ack slot
                                req_we <= 1'b0; // R11
                                req_addr <= ptr; // R13
                                req_tgl <= !req_tgl;
                            end
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_DEVACK: begin
                    if (scl_fall) begin
                        if (dir_rd) begin
                            state <= ST_RDDATA;
                            tx <= rd_data;
                        end else begin
                            state <= ST_REGADDR;
                        end
                    end
                end
                ST_REGADDR: begin
                    if (scl_fall && cnt == BITS_PER_BYTE) begin
                        cnt <= CNT_ZERO;
                        ptr <= shreg; // R6
                        state <= ST_REGACK;
                    end
                end
                ST_REGACK, ST_WRACK: begin
                    if (scl_fall) begin
                        state <= ST_WRDATA;
                    end
                end
                ST_WRDATA: begin
                    if (scl_fall && cnt == BITS_PER_BYTE) begin
                        cnt <= CNT_ZERO;
                        req_we <= 1'b1; // R7
                        req_addr <= ptr;
                        req_wdata <= shreg;
                        req_tgl <= !req_tgl;
                        ptr <= ptr + REG_STEP; // R7
                        state <= ST_WRACK;
                    end
                end
                ST_RDDATA: begin
                    if (scl_fall) begin
                        if (cnt == LAST_TX_BIT) begin
                            cnt <= CNT_ZERO;
                            state <= ST_RDACK;
                            ptr <= ptr + REG_STEP; // R9
                            req_we <= 1'b0;
                            req_addr <= ptr + REG_STEP;
                            req_tgl <= !req_tgl;
                        end else begin
                            tx <= {tx[6:0], 1'b0};
                            cnt <= cnt + CNT_STEP;
                        end
                    end
                end
                ST_RDACK: begin
                    if (scl_rise) begin
                        mnack <= sda_f; // R12
                    end
                    if (scl_fall) begin
                        if (mnack) begin
                            state <= ST_IDLE; // R10
                        end else begin
                            state <= ST_RDDATA;
                            tx <= rd_data;
                        end
                    end
                end
            endcase
        end
    end

    // Answer data crosses back by toggle; the word is stable once it flips
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            rsp_s1 <= 1'b0;
            rsp_s2 <= 1'b0;
            rsp_seen <= 1'b0;
            rd_data <= REG_DEFAULT;
        end else begin
            rsp_s1 <= rsp_tgl;
            rsp_s2 <= rsp_s1;
            if (rsp_s2 != rsp_seen) begin
                rsp_seen <= rsp_s2;
                rd_data <= xfer_rdata;
            end
        end
    end

    // Open drain: only ever pull low, released on a master nack
    assign sda_o = 1'b0;
    assign sda_oe = (state == ST_DEVACK) || (state == ST_REGACK) || (state == ST_WRACK)
        || ((state == ST_RDDATA) && !tx[7]); // R10

    // ------------------------------------------------------------------
    // System domain: request crossing and default sweep
    // ------------------------------------------------------------------
    logic req_s1, req_s2, req_seen, i2c_pend;
    logic sweep_busy;
    logic [7:0] sweep_cnt;
    i2cr_op_t op_state;
    logic mem_we;
    logic [7:0] mem_addr, mem_wdata, mem_rdata;
    logic op_free, wr_ready, grant_i2c, grant_aw, grant_ar, soft_hit;
    logic aw_got, w_got, ar_got;
    logic [AXI_AW-1:0] aw_addr, ar_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
        end
    end
    assign i2c_pend = req_s2 != req_seen;

    assign op_free = (op_state == OP_IDLE) && !sweep_busy; // R1
    assign wr_ready = aw_got && w_got && !s_axi_bvalid;
    assign grant_i2c = op_free && i2c_pend;
    assign grant_aw = op_free && !i2c_pend && wr_ready;
    assign grant_ar = (op_state == OP_IDLE) && ar_got && !s_axi_rvalid
        && ((!sweep_busy && !i2c_pend && !wr_ready) || (sweep_busy && ar_addr[AXI_SPACE_BIT]));
    assign soft_hit = mem_we && !sweep_busy && (mem_addr == RESET_REG_IDX)
        && mem_wdata[SOFT_RESET_POS];

    always_comb begin
        mem_we = 1'b0;
        mem_addr = ar_addr[AXI_IDX_MSB:AXI_IDX_LSB];
        mem_wdata = REG_DEFAULT;
        if (sweep_busy) begin
            mem_we = 1'b1; // R1
            mem_addr = sweep_cnt;
        end else if (grant_i2c) begin
            mem_we = req_we;
            mem_addr = req_addr;
            mem_wdata = req_wdata;
        end else if (grant_aw) begin
            mem_we = !aw_addr[AXI_SPACE_BIT] && w_strb[0];
            mem_addr = aw_addr[AXI_IDX_MSB:AXI_IDX_LSB];
            mem_wdata = w_data[7:0];
        end
    end

    i2cr_regmem u_mem (
        .aclk(aclk),
        .we(mem_we),
        .addr(mem_addr),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // The sweep overwrites the reset register too, so the bit clears itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sweep_busy <= 1'b1; // R1
            sweep_cnt <= REG_DEFAULT;
        end else if (soft_hit) begin
            sweep_busy <= 1'b1; // R2
            sweep_cnt <= REG_DEFAULT;
        end else if (sweep_busy) begin
            sweep_cnt <= sweep_cnt + REG_STEP;
            if (sweep_cnt == REG_LAST) begin
                sweep_busy <= 1'b0;
            end
        end
    end

    // Link side stays in reset until the power-up sweep ends, so even a short reset reaches it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            link_hold <= 1'b1; // R1
        end else if (!sweep_busy) begin
            link_hold <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_state <= OP_IDLE;
            req_seen <= 1'b0;
            rsp_tgl <= 1'b0;
            xfer_rdata <= REG_DEFAULT;
        end else begin
            unique case (op_state)
                OP_IDLE: begin
                    if (grant_i2c) begin
                        op_state <= OP_I2C; // R5
                        req_seen <= req_s2;
                    end else if (grant_ar) begin
                        op_state <= OP_AXR;
                    end
                end
                OP_I2C: begin
                    xfer_rdata <= mem_rdata;
                    rsp_tgl <= !rsp_tgl;
                    op_state <= OP_IDLE;
                end
                OP_AXR: begin
                    op_state <= OP_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_got;
    assign s_axi_wready = !w_got;
    assign s_axi_arready = !ar_got;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_got) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_got) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (grant_aw) begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (!aw_addr[AXI_SPACE_BIT] || aw_addr == STATUS_ADDR)
                    ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got <= 1'b0;
            ar_addr <= '0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && !ar_got) begin
                ar_got <= 1'b1;
                ar_addr <= s_axi_araddr;
            end
            if (op_state == OP_AXR) begin
                ar_got <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= '0;
                if (!ar_addr[AXI_SPACE_BIT]) begin
                    s_axi_rdata[7:0] <= mem_rdata;
                end else if (ar_addr == STATUS_ADDR) begin
                    s_axi_rdata[STAT_BUSY_POS] <= sweep_busy;
                    s_axi_rdata[STAT_PEND_POS] <= i2c_pend;
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_power_sweep: assert property (@(posedge aclk) disable iff (!aresetn)
        !$past(aresetn) |-> sweep_busy && sweep_cnt == REG_DEFAULT) // R1
        else $error("sweep not started after reset");
    a_sweep_end: assert property (@(posedge aclk) disable iff (!aresetn)
        sweep_busy && sweep_cnt == REG_LAST |=> !sweep_busy) // R1
        else $error("sweep did not end after last register");
    a_sweep_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
        sweep_busy |-> !grant_i2c && !grant_aw) // R1
        else $error("access served during sweep");
    a_soft_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_hit |=> sweep_busy && sweep_cnt == REG_DEFAULT) // R2
        else $error("soft reset did not restart sweep");
    a_i2c_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        grant_i2c |=> op_state == OP_I2C ##1 $changed(rsp_tgl)) // R5
        else $error("serial request not answered in two cycles");
    a_addr_ack: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == ST_DEVADDR && scl_fall && cnt == BITS_PER_BYTE && shreg[7:1] == DEV_ADDR
        |=> state == ST_DEVACK && sda_oe && dir_rd == $past(shreg[0])) // R12
        else $error("own address not acknowledged");
    a_write_step: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == ST_WRDATA && scl_fall && cnt == BITS_PER_BYTE
        |=> req_we && req_addr == $past(ptr) && ptr == $past(ptr) + REG_STEP
        && $changed(req_tgl)) // R7
        else $error("write byte not stored and stepped");
    a_read_step: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == ST_RDDATA && scl_fall && cnt == LAST_TX_BIT && !start_det && !stop_det
        |=> state == ST_RDACK && !sda_oe && ptr == $past(ptr) + REG_STEP) // R9
        else $error("read byte end mishandled");
    a_nack_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        state == ST_RDACK && scl_fall && mnack && !start_det && !stop_det
        |=> state == ST_IDLE && !sda_oe) // R10
        else $error("data not released on nack");
    a_ptr_kept: assert property (@(posedge link_clk) disable iff (!link_rst_n)
        start_det |=> ptr == $past(ptr) && state == ST_DEVADDR) // R13
        else $error("pointer lost at start");

endmodule

// File: rtl/i2cr_pkg.sv
// Constants and types shared by the serial register access block
package i2cr_pkg;

    // ------------------------------------------------------------------
    // Register space
    // ------------------------------------------------------------------
    localparam int unsigned REG_AW = 8;
    localparam int unsigned REG_DW = 8;
    localparam int unsigned REG_COUNT = 256;
    localparam logic [7:0] REG_DEFAULT = 8'h00;
    localparam logic [7:0] REG_LAST = 8'hFF;
    localparam logic [7:0] REG_STEP = 8'h01;
    localparam logic [7:0] RESET_REG_IDX = 8'h0C;
    localparam int unsigned SOFT_RESET_POS = 0;

    // ------------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h22;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_STEP = 4'h1;

    // ------------------------------------------------------------------
    // AXI4-Lite map
    // ------------------------------------------------------------------
    localparam int unsigned AXI_AW = 11;
    localparam int unsigned AXI_IDX_LSB = 2;
    localparam int unsigned AXI_IDX_MSB = 9;
    localparam int unsigned AXI_SPACE_BIT = 10;
    localparam logic [10:0] STATUS_ADDR = 11'h400;
    localparam int unsigned STAT_BUSY_POS = 0;
    localparam int unsigned STAT_PEND_POS = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_DEVADDR = 4'b0001,
        ST_DEVACK = 4'b0010,
        ST_REGADDR = 4'b0011,
        ST_REGACK = 4'b0100,
        ST_WRDATA = 4'b0101,
        ST_WRACK = 4'b0110,
        ST_RDDATA = 4'b0111,
        ST_RDACK = 4'b1000
    } i2cr_state_t;

    typedef enum logic [1:0] {
        OP_IDLE = 2'b00,
        OP_I2C = 2'b01,
        OP_AXR = 2'b10
    } i2cr_op_t;

endpackage

// File: rtl/i2cr_regmem.sv
// Single-port byte memory holding the register space
`timescale 1ns/1ps
module i2cr_regmem
    import i2cr_pkg::*;
(
    input wire logic aclk,
    input wire logic we,
    input wire logic [REG_AW-1:0] addr,
    input wire logic [REG_DW-1:0] wdata,
    output logic [REG_DW-1:0] rdata
);

    logic [REG_DW-1:0] mem [REG_COUNT];

    // Contents are not reset here; the owner sweeps defaults in after reset
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge aclk) begin
        rdata <= mem[addr];
    end

endmodule

// File: sim/i2cr_master_model.sv
// Behavioural two-wire bus master driving the serial side of the block
`timescale 1ns/1ps
module i2cr_master_model (
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    // Quarter of a 400 kHz bit; the low phase is long enough for the slave's sampling delay
    localparam int Q = 625;
    logic drv;
    // Open drain with pull-up: either party pulling low wins
    assign sda = drv & ~sda_oe;
    initial begin
        scl = 1'b1;
        drv = 1'b1;
    end
    // Also serves as repeated start when entered with the clock low
    task start;
        drv = 1'b1;
        #Q scl = 1'b1;
        #Q drv = 1'b0;
        #Q scl = 1'b0;
        #Q;
    endtask
    task stop;
        drv = 1'b0;
        #Q scl = 1'b1;
        #Q drv = 1'b1;
        #(4*Q);
    endtask
    task bitx(input logic b, output logic s);
        drv = b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
        #Q;
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], s);
        end
        bitx(1'b1, s);
        ack = ~s;
    endtask
    // Ack asks for more; a high ack slot ends the read
    task rbyte(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, s);
            d[i] = s;
        end
        bitx(~ack, s);
    endtask
endmodule

// File: sim/i2cr_top_bench.sv
// Self-checking bench for the serial register access block
`timescale 1ns/1ps
module i2cr_top_bench;
    import i2cr_pkg::*;
    logic aclk, aresetn, link_clk, scl, sda, sda_oe, ack;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [AXI_AW-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] b;
    logic [7:0] wr_set [3] = '{8'h00, 8'h5A, 8'h00};
    int n_fail, checks;
    i2cr_top i_i2cr_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(), .sda_oe(sda_oe));
    i2cr_master_model i_i2cr_master_model (.sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #62.5 link_clk = ~link_clk;
    end
    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task results;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task lim(input bit over);
        if (over) begin
            n_fail++;
            results;
        end
    endtask
    task axw(input logic [7:0] idx, input logic [7:0] d);
        int n;
        logic at, wt, bt;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= {1'b0, idx, 2'b00};
        wdata <= {24'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid === 1'b1;
            r = bresp;
            @(posedge aclk);
            n++;
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end while (!bt && n < 2000);
        bready <= 1'b0;
        lim(n >= 2000);
        chk("bresp", r, RESP_OKAY);
    endtask
    task axr(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic at, rt;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge aclk);
            at = arvalid && arready;
            rt = rvalid === 1'b1;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            n++;
            if (at) arvalid <= 1'b0;
        end while (!rt && n < 2000);
        rready <= 1'b0;
        lim(n >= 2000);
    endtask
    task sweep_wait;
        int n;
        n = 0;
        do begin
            axr(STATUS_ADDR, v, rs);
            n++;
        end while (v[STAT_BUSY_POS] !== 1'b0 && n < 200);
        lim(n >= 200);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_init;
        axr(STATUS_ADDR, v, rs);
        chk("busy", v[STAT_BUSY_POS], 1'b1);
        sweep_wait;
        axr(11'h00C, v, rs);
        chk("reg3", v, 32'h0000_0000);
        axr(11'h404, v, rs);
        chk("unmapped", rs, RESP_SLVERR);
        $display("init done");
    endtask
    task t_write;
        axw(8'h06, 8'h6C);
        i_i2cr_master_model.start;
        i_i2cr_master_model.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ack);
        chk("ack addr", ack, 1'b1);
        i_i2cr_master_model.wbyte(8'h03, ack);
        chk("ack reg", ack, 1'b1);
        for (int i = 0; i < 3; i++) begin
            i_i2cr_master_model.wbyte(wr_set[i], ack);
            chk("ack data", ack, 1'b1);
        end
        i_i2cr_master_model.stop;
        for (int i = 0; i < 3; i++) begin
            axr(11'(4 * (3 + i)), v, rs);
            chk("stored", v, {24'h0000, wr_set[i]});
        end
        $display("write done");
    endtask
    // Pointer was left at 0x06 by the write burst
    task t_cur;
        i_i2cr_master_model.start;
        i_i2cr_master_model.wbyte({DEV_ADDR_DEFAULT, 1'b1}, ack);
        chk("ack rd", ack, 1'b1);
        i_i2cr_master_model.rbyte(1'b0, b);
        chk("cur byte", b, 8'h6C);
        i_i2cr_master_model.stop;
        $display("current read done");
    endtask
    task t_addr;
        axw(8'h0A, 8'h49);
        axw(8'h0B, 8'h2F);
        i_i2cr_master_model.start;
        i_i2cr_master_model.wbyte({DEV_ADDR_DEFAULT, 1'b0}, ack);
        i_i2cr_master_model.wbyte(8'h0A, ack);
        i_i2cr_master_model.start;
        i_i2cr_master_model.wbyte({DEV_ADDR_DEFAULT, 1'b1}, ack);
        i_i2cr_master_model.rbyte(1'b1, b);
        chk("rd K", b, 8'h49);
        i_i2cr_master_model.rbyte(1'b0, b);
        chk("rd K+1", b, 8'h2F);
        chk("released", sda_oe, 1'b0);
        i_i2cr_master_model.stop;
        i_i2cr_master_model.start;
        i_i2cr_master_model.wbyte({DEV_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
        chk("foreign addr", ack, 1'b0);
        i_i2cr_master_model.stop;
        $display("addressed read done");
    endtask
    task t_soft;
        axw(RESET_REG_IDX, 8'h01);
        sweep_wait;
        axr(11'h010, v, rs);
        chk("reg4 default", v, 32'h0000_0000);
        axr(11'h028, v, rs);
        chk("reg10 default", v, 32'h0000_0000);
        $display("soft reset done");
    endtask
    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_init;
        #8000;
        t_write;
        t_cur;
        t_addr;
        t_soft;
        results;
    end
endmodule
